// file: design/wdtr_pkg.sv
// Package of constants and types for the watchdog with locked reload.
package wdtr_pkg;

   // ---------------------------------------------------------------
   // Register map: printed indices, byte address is four times index
   // ---------------------------------------------------------------
   localparam logic [31:0] REG_HIGH_IDX   = 32'h00FF_E042;
   localparam logic [31:0] REG_LOW_IDX    = 32'h00FF_E043;
   localparam logic [31:0] REG_STATUS_IDX = 32'h00FF_E044;
   localparam logic [31:0] REG_HIGH_ADDR  = {REG_HIGH_IDX[29:0], 2'b00};
   localparam logic [31:0] REG_LOW_ADDR   = {REG_LOW_IDX[29:0], 2'b00};
   localparam logic [31:0] REG_STATUS_ADDR = {REG_STATUS_IDX[29:0], 2'b00};

   // ---------------------------------------------------------------
   // Reset values and unlock keys
   // ---------------------------------------------------------------
   localparam logic [7:0]  RELOAD_HIGH_RST = 8'h04;
   localparam logic [7:0]  RELOAD_LOW_RST  = 8'h00;
   localparam logic [15:0] COUNT_RST       = 16'h0400;
   localparam logic [7:0]  UNLOCK_KEY1     = 8'h55;
   localparam logic [7:0]  UNLOCK_KEY2     = 8'hAA;
   localparam logic [15:0] COUNT_ONE       = 16'h0001;
   localparam logic [15:0] COUNT_ZERO      = 16'h0000;

   // ---------------------------------------------------------------
   // Status register field positions
   // ---------------------------------------------------------------
   localparam int STAT_ENABLED  = 0;
   localparam int STAT_WDCAUSE  = 1;
   localparam int STAT_STPCAUSE = 2;
   localparam int STAT_UNLOCKED = 3;
   localparam int STAT_RESPRST  = 4;

   // ---------------------------------------------------------------
   // Timing: system clock and nominal watchdog oscillator
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int OSC_PERIOD_NS = 100000;
   localparam int TICK_CYCLES   = OSC_PERIOD_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      WDTR_SEL_NONE,
      WDTR_SEL_HIGH,
      WDTR_SEL_LOW,
      WDTR_SEL_STATUS
   } wdtr_sel_t;

   typedef enum {
      WDTR_LOCKED,
      WDTR_GOT_KEY1,
      WDTR_OPEN_HIGH,
      WDTR_OPEN_LOW
   } wdtr_lock_t;

endpackage

// file: design/wdtr_tick_gen.sv
// Divider that stands in for the watchdog oscillator as a tick pulse.
`timescale 1ns/100ps
module wdtr_tick_gen #(
   parameter int TICK_CYCLES = wdtr_pkg::TICK_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic oscEnable,
   output logic      tick
);

   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] div_q;

   // A stopped oscillator clears the divider so no stray tick appears.
   always_ff @(posedge clk) begin
      if (rst || !oscEnable) begin
         div_q <= '0;
      end else if (div_q == LAST) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + CW'(1);
      end
   end

   assign tick = oscEnable && (div_q == LAST);

endmodule

// file: design/wdtr_unlock.sv
// Unlock sequencer that gates writes into the two reload bytes.
`timescale 1ns/100ps
module wdtr_unlock (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       wrHigh,
   input  wire logic       wrLow,
   input  wire logic [7:0] wrData,
   output logic            highWe,
   output logic            lowWe,
   output logic            unlocked
);

   wdtr_pkg::wdtr_lock_t state_q;

   // Key writes never reach the stored byte; only the open states do.
   assign highWe   = wrHigh && (state_q == wdtr_pkg::WDTR_OPEN_HIGH);
   assign lowWe    = wrLow && (state_q == wdtr_pkg::WDTR_OPEN_LOW);
   assign unlocked = (state_q != wdtr_pkg::WDTR_LOCKED);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= wdtr_pkg::WDTR_LOCKED;
      end else begin
         case (state_q)
            wdtr_pkg::WDTR_LOCKED: begin
               if (wrHigh && wrData == wdtr_pkg::UNLOCK_KEY1) begin
                  state_q <= wdtr_pkg::WDTR_GOT_KEY1;
               end
            end
            wdtr_pkg::WDTR_GOT_KEY1: begin
               if (wrHigh && wrData == wdtr_pkg::UNLOCK_KEY2) begin
                  state_q <= wdtr_pkg::WDTR_OPEN_HIGH;
               end else if (wrHigh || wrLow) begin
                  state_q <= wdtr_pkg::WDTR_LOCKED;
               end
            end
            wdtr_pkg::WDTR_OPEN_HIGH: begin
               if (wrHigh) begin
                  state_q <= wdtr_pkg::WDTR_OPEN_LOW;
               end else if (wrLow) begin
                  state_q <= wdtr_pkg::WDTR_LOCKED;
               end
            end
            wdtr_pkg::WDTR_OPEN_LOW: begin
               // The low byte closes the sequence; a high-byte write aborts it.
               if (wrHigh || wrLow) begin
                  state_q <= wdtr_pkg::WDTR_LOCKED;
               end
            end
            default: begin
               state_q <= wdtr_pkg::WDTR_LOCKED;
            end
         endcase
      end
   end

endmodule

// file: design/wdtr_watchdog.sv
// Watchdog down-counter with locked reload registers on an APB slave.
//
// Overview of operation
// - A time-out is declared when the down-counter reaches zero.
// - A nonvolatile option picks exception request or short reset.
// - Exception response in normal operation raises an exception request.
// - After an exception time-out the counter reloads itself and counts on.
// - Exception response in stop mode starts recovery and posts the exception.
// - A stop-mode time-out sets both watchdog cause and stop cause.
// - Reset response in normal operation forces reset, sets watchdog cause.
// - After reset the counter holds its defined reset value.
// - Reset response in stop mode starts stop recovery, not a reset.
// - The two unlock writes leave the stored high byte unchanged.
// - Each refresh instruction copies the reload value into the counter.
// - Reload value is high byte in bits 15:8, low byte in 7:0.
// - Reads of either reload address return the live count byte.
// - The counter steps on a nominal 10 kHz tick, stopped when disabled.
// - Enable comes from the first refresh or the always-on option.
// - On first enable the counter loads the reload value, then counts.
// - While halted under the debugger the counter is refreshed always.
`timescale 1ns/100ps
module wdtr_watchdog #(
   parameter int TICK_CYCLES = wdtr_pkg::TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        refreshInstr,
   input  wire logic        stopMode,
   input  wire logic        debugHalt,
   input  wire logic        rcOscEnable,
   input  wire logic        optResetResponse,
   input  wire logic        optAlwaysOn,
   output logic             exceptionReq,
   output logic             deviceResetReq,
   output logic             stopRecoveryReq,
   output logic             wdCauseSet,
   output logic             stopCauseSet
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0]          reloadHigh_q;
   logic [7:0]          reloadLow_q;
   logic [15:0]         reloadVal;
   logic [15:0]         count_q;
   logic                enabled_q;
   logic                startEn;
   logic                refreshNow;
   logic                timeoutHit;
   logic                rcTick;
   logic                wdCause_q;
   logic                stopCause_q;
   logic                exceptionReq_q;
   logic                deviceResetReq_q;
   logic                stopRecoveryReq_q;
   logic                wdCauseSet_q;
   logic                stopCauseSet_q;
   logic [31:0]         prdata_q;
   wdtr_pkg::wdtr_sel_t sel;
   logic                setupPh;
   logic                accessPh;
   logic                wrAccess;
   logic                wrHigh;
   logic                wrLow;
   logic                wrStatus;
   logic                highWe;
   logic                lowWe;
   logic                unlocked;
   logic [31:0]         statusWord;

   // ---------------------------------------------------------------
   // Address decoding
   // ---------------------------------------------------------------
   // The whole byte address is compared, so aliases of the registers
   // fall into the unmapped space and answer with an error.
   function automatic wdtr_pkg::wdtr_sel_t decode(input logic [31:0] a);
      if (a == wdtr_pkg::REG_HIGH_ADDR) begin
         decode = wdtr_pkg::WDTR_SEL_HIGH;
      end else if (a == wdtr_pkg::REG_LOW_ADDR) begin
         decode = wdtr_pkg::WDTR_SEL_LOW;
      end else if (a == wdtr_pkg::REG_STATUS_ADDR) begin
         decode = wdtr_pkg::WDTR_SEL_STATUS;
      end else begin
         decode = wdtr_pkg::WDTR_SEL_NONE;
      end
   endfunction

   // Byte registers sit in lane 0 of the read word; upper lanes read zero.
   function automatic logic [31:0] laneZero(input logic [7:0] b);
      laneZero = {24'h000000, b};
   endfunction

   // A status flag clears when software writes a one to its position.
   function automatic logic clearsBit(input logic        wr,
                                      input logic [31:0] d,
                                      input int          pos);
      clearsBit = wr && d[pos];
   endfunction

   assign sel      = decode(paddr);
   assign setupPh  = psel && !penable;
   assign accessPh = psel && penable;
   // The slave never stretches a transfer.
   assign pready   = 1'b1;
   assign pslverr  = accessPh && (sel == wdtr_pkg::WDTR_SEL_NONE);
   assign prdata   = prdata_q;

   // Byte registers take their data from lane 0 only.
   assign wrAccess = accessPh && pwrite && pstrb[0];
   assign wrHigh   = wrAccess && (sel == wdtr_pkg::WDTR_SEL_HIGH);
   assign wrLow    = wrAccess && (sel == wdtr_pkg::WDTR_SEL_LOW);
   assign wrStatus = wrAccess && (sel == wdtr_pkg::WDTR_SEL_STATUS);

   // ---------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------
   wdtr_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk       (clk),
      .rst       (rst),
      .oscEnable (rcOscEnable),
      .tick      (rcTick)
   );

   // The sequencer is kept apart so that the order of the four writes
   // is checked in one place; the byte registers only see its enables.
   wdtr_unlock u_unlock (
      .clk      (clk),
      .rst      (rst),
      .wrHigh   (wrHigh),
      .wrLow    (wrLow),
      .wrData   (pwdata[7:0]),
      .highWe   (highWe),
      .lowWe    (lowWe),
      .unlocked (unlocked)
   );

   // ---------------------------------------------------------------
   // Reload registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         reloadHigh_q <= wdtr_pkg::RELOAD_HIGH_RST;
      end else if (highWe) begin
         reloadHigh_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reloadLow_q <= wdtr_pkg::RELOAD_LOW_RST;
      end else if (lowWe) begin
         reloadLow_q <= pwdata[7:0];
      end
   end

   assign reloadVal = {reloadHigh_q, reloadLow_q};

   // ---------------------------------------------------------------
   // Enable and counter
   // ---------------------------------------------------------------
   // A debug halt refreshes on every cycle, which also keeps the
   // time-out path shut while the core is stopped.
   assign refreshNow = refreshInstr || debugHalt;
   assign startEn    = !enabled_q && (refreshInstr || optAlwaysOn);

   always_ff @(posedge clk) begin
      if (rst) begin
         enabled_q <= 1'b0;
      end else if (startEn) begin
         enabled_q <= 1'b1;
      end
   end

   // A reload value of zero would keep this compare from ever firing;
   // software keeps the value at four or more.
   assign timeoutHit = enabled_q && rcTick && !refreshNow &&
                       (count_q == wdtr_pkg::COUNT_ONE);

   // Priority: first enable, then refresh, then the self reload that
   // follows the zero cycle, then the tick. A refresh always wins so
   // that software can never race the time-out path.
   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= wdtr_pkg::COUNT_RST;
      end else if (startEn) begin
         count_q <= reloadVal;
      end else if (refreshNow) begin
         count_q <= reloadVal;
      end else if (enabled_q && count_q == wdtr_pkg::COUNT_ZERO) begin
         count_q <= reloadVal;
      end else if (enabled_q && rcTick) begin
         count_q <= count_q - wdtr_pkg::COUNT_ONE;
      end
   end

   // ---------------------------------------------------------------
   // Time-out responses
   // ---------------------------------------------------------------
   // In stop mode an exception response raises both the exception and
   // the recovery request; the interrupt controller holds the exception
   // until recovery has brought the core back.
   always_ff @(posedge clk) begin
      if (rst) begin
         exceptionReq_q    <= 1'b0;
         deviceResetReq_q  <= 1'b0;
         stopRecoveryReq_q <= 1'b0;
      end else begin
         exceptionReq_q    <= timeoutHit && !optResetResponse;
         deviceResetReq_q  <= timeoutHit && optResetResponse && !stopMode;
         stopRecoveryReq_q <= timeoutHit && stopMode;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wdCauseSet_q   <= 1'b0;
         stopCauseSet_q <= 1'b0;
      end else begin
         wdCauseSet_q   <= timeoutHit;
         stopCauseSet_q <= timeoutHit && stopMode;
      end
   end

   assign exceptionReq    = exceptionReq_q;
   assign deviceResetReq  = deviceResetReq_q;
   assign stopRecoveryReq = stopRecoveryReq_q;
   assign wdCauseSet      = wdCauseSet_q;
   assign stopCauseSet    = stopCauseSet_q;

   // ---------------------------------------------------------------
   // Sticky cause copies, write one to clear, a new cause wins
   // ---------------------------------------------------------------
   // Letting the set win means a time-out that lands on the clear write
   // is never lost; software sees the flag again on its next read.
   always_ff @(posedge clk) begin
      if (rst) begin
         wdCause_q <= 1'b0;
      end else if (timeoutHit) begin
         wdCause_q <= 1'b1;
      end else if (clearsBit(wrStatus, pwdata, wdtr_pkg::STAT_WDCAUSE)) begin
         wdCause_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stopCause_q <= 1'b0;
      end else if (timeoutHit && stopMode) begin
         stopCause_q <= 1'b1;
      end else if (clearsBit(wrStatus, pwdata, wdtr_pkg::STAT_STPCAUSE)) begin
         stopCause_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read data, captured in the setup cycle
   // ---------------------------------------------------------------
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[wdtr_pkg::STAT_ENABLED]  = enabled_q;
      statusWord[wdtr_pkg::STAT_WDCAUSE]  = wdCause_q;
      statusWord[wdtr_pkg::STAT_STPCAUSE] = stopCause_q;
      statusWord[wdtr_pkg::STAT_UNLOCKED] = unlocked;
      statusWord[wdtr_pkg::STAT_RESPRST]  = optResetResponse;
   end

   // The count is sampled one cycle before the access edge; it can be
   // at most one tick stale, which software cannot tell apart.
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (setupPh && !pwrite) begin
         if (sel == wdtr_pkg::WDTR_SEL_HIGH) begin
            prdata_q <= laneZero(count_q[15:8]);
         end else if (sel == wdtr_pkg::WDTR_SEL_LOW) begin
            prdata_q <= laneZero(count_q[7:0]);
         end else if (sel == wdtr_pkg::WDTR_SEL_STATUS) begin
            prdata_q <= statusWord;
         end else begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

endmodule

// file: test/wdtr_watchdog_checker.sv
// Checker of the watchdog request pulses and the bus answer.
`timescale 1ns/100ps
module wdtr_watchdog_checker #(
   parameter int TICK_CYCLES = wdtr_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic refreshInstr,
   input wire logic stopMode,
   input wire logic debugHalt,
   input wire logic rcOscEnable,
   input wire logic optResetResponse,
   input wire logic exceptionReq,
   input wire logic deviceResetReq,
   input wire logic stopRecoveryReq,
   input wire logic wdCauseSet,
   input wire logic stopCauseSet
);
   // Cycles since the last time-out; the legal reload floor bounds the gap.
   logic [31:0] gapCount_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         gapCount_q <= 32'hFFFF_FFFF;
      end else if (wdCauseSet) begin
         gapCount_q <= 32'h0000_0000;
      end else if (gapCount_q != 32'hFFFF_FFFF) begin
         gapCount_q <= gapCount_q + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_cause_one_cycle: assert property (wdCauseSet |=> !wdCauseSet)
      else $error("cause pulse longer than one cycle");
   a_no_lone_req: assert property ((exceptionReq || deviceResetReq ||
      stopRecoveryReq || stopCauseSet) |-> wdCauseSet)
      else $error("request without time-out");
   a_exc_by_option: assert property (wdCauseSet |->
      exceptionReq == !$past(optResetResponse))
      else $error("exception request does not follow option");
   a_reset_normal: assert property (wdCauseSet |-> deviceResetReq ==
      ($past(optResetResponse) && !$past(stopMode)))
      else $error("reset request wrong");
   a_stop_recover: assert property (wdCauseSet |->
      stopRecoveryReq == $past(stopMode) && stopCauseSet == $past(stopMode))
      else $error("stop recovery or stop cause wrong");
   a_debug_quiet: assert property ($past(debugHalt) |-> !wdCauseSet)
      else $error("time-out while halted");
   a_refresh_quiet: assert property ($past(refreshInstr) |->
      !wdCauseSet)
      else $error("time-out on refresh");
   a_osc_off_quiet: assert property (!$past(rcOscEnable) |->
      !wdCauseSet)
      else $error("time-out with oscillator off");
   a_timeout_gap: assert property (wdCauseSet |->
      gapCount_q >= 32'(4 * TICK_CYCLES - 1))
      else $error("time-outs too close");
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("access phase not answered");
endmodule

bind wdtr_watchdog wdtr_watchdog_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
   .refreshInstr(refreshInstr), .stopMode(stopMode), .debugHalt(debugHalt),
   .rcOscEnable(rcOscEnable), .optResetResponse(optResetResponse),
   .exceptionReq(exceptionReq), .deviceResetReq(deviceResetReq),
   .stopRecoveryReq(stopRecoveryReq), .wdCauseSet(wdCauseSet),
   .stopCauseSet(stopCauseSet));

// file: test/wdtr_far_side.sv
// Far-side model: refresh source, interrupt controller and reset logic.
`timescale 1ns/100ps
module wdtr_far_side (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic kick,
   input  wire logic exceptionReq,
   input  wire logic deviceResetReq,
   input  wire logic stopRecoveryReq,
   input  wire logic wdCauseSet,
   output logic      refreshInstr,
   output int        excCount,
   output int        rstCount,
   output int        recCount,
   output int        causeCount
);
   // A held kick still gives one refresh instruction, as the CPU would.
   logic kick_q;
   always_ff @(posedge clk) begin
      kick_q <= kick;
      refreshInstr <= kick && !kick_q;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         excCount <= 0;
         rstCount <= 0;
         recCount <= 0;
         causeCount <= 0;
      end else begin
         excCount <= excCount + int'(exceptionReq);
         rstCount <= rstCount + int'(deviceResetReq);
         recCount <= recCount + int'(stopRecoveryReq);
         causeCount <= causeCount + int'(wdCauseSet);
      end
   end
endmodule

// file: test/wdtr_watchdog_test.sv
// Self-checking bench for the watchdog with locked reload.
`timescale 1ns/100ps
module wdtr_watchdog_test;
   localparam int          TC = 4;
   localparam logic [31:0] HI = wdtr_pkg::REG_HIGH_ADDR;
   localparam logic [31:0] LO = wdtr_pkg::REG_LOW_ADDR;
   localparam logic [31:0] ST = wdtr_pkg::REG_STATUS_ADDR;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, kick, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        stopMode, debugHalt, rcOscEnable, optResetResponse;
   logic        refreshInstr, exceptionReq, deviceResetReq, stopRecoveryReq;
   logic        wdCauseSet, stopCauseSet, optAlwaysOn;
   logic [15:0] v;
   int          failures, num_checks, seed, rel, n, eExc, eRst, eRec, nb;
   int          excCount, rstCount, recCount, causeCount;

   wdtr_watchdog #(.TICK_CYCLES(TC)) u_wdtr_watchdog (
      .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .refreshInstr(refreshInstr),
      .stopMode(stopMode), .debugHalt(debugHalt),
      .rcOscEnable(rcOscEnable), .optResetResponse(optResetResponse),
      .optAlwaysOn(optAlwaysOn), .exceptionReq(exceptionReq),
      .deviceResetReq(deviceResetReq), .stopRecoveryReq(stopRecoveryReq),
      .wdCauseSet(wdCauseSet), .stopCauseSet(stopCauseSet));
   wdtr_far_side u_wdtr_far_side (
      .clk(clk), .rst(rst), .kick(kick), .exceptionReq(exceptionReq),
      .deviceResetReq(deviceResetReq), .stopRecoveryReq(stopRecoveryReq),
      .wdCauseSet(wdCauseSet), .refreshInstr(refreshInstr),
      .excCount(excCount), .rstCount(rstCount), .recCount(recCount),
      .causeCount(causeCount));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e,
                      input string m);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, m, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // The access phase stands until the slave answers; only the
      // watchdog process ends a wait that never does.
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic setrel(input logic [15:0] x);
      apb(1'b1, HI, {24'h0, wdtr_pkg::UNLOCK_KEY1});
      apb(1'b1, HI, {24'h0, wdtr_pkg::UNLOCK_KEY2});
      apb(1'b1, HI, {24'h0, x[15:8]});
      apb(1'b1, LO, {24'h0, x[7:0]});
      rel = int'(x);
   endtask
   task automatic refresh;
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic chkcount(input int e);
      apb(1'b0, HI, 32'h0);
      chk(rd, 32'((e >> 8) & 255), "count high");
      apb(1'b0, LO, 32'h0);
      chk(rd, 32'(e & 255), "count low");
   endtask
   task automatic waitto(input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (wdCauseSet !== 1'b1 && n < lim);
      if (wdCauseSet !== 1'b1) begin
         failures++;
      end
   endtask
   function automatic logic [31:0] stw(input int en, wd, sc, un, rr);
      int w;
      w = en << wdtr_pkg::STAT_ENABLED;
      w |= wd << wdtr_pkg::STAT_WDCAUSE;
      w |= sc << wdtr_pkg::STAT_STPCAUSE;
      w |= un << wdtr_pkg::STAT_UNLOCKED;
      w |= rr << wdtr_pkg::STAT_RESPRST;
      return 32'(w);
   endfunction
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      {rst, kick, optAlwaysOn} = 3'b100;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {stopMode, debugHalt, rcOscEnable, optResetResponse} = 4'h0;
      {failures, num_checks, eExc, eRst, eRec} = '0;
      seed = 78;
      rel = int'(wdtr_pkg::COUNT_RST);
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chkcount(rel);
      apb(1'b0, 32'h0000_0100, 32'h0);
      chk(err, 1, "unmapped error");
      chk(rd, 0, "unmapped data");
      rcOscEnable <= 1'b1;
      repeat (4400) @(posedge clk);
      chk(causeCount, 0, "counting before enable");
      rcOscEnable <= 1'b0;
      $display("reset and enable test done");
      apb(1'b1, LO, 32'h0000_0033);
      apb(1'b1, HI, {24'h0, wdtr_pkg::UNLOCK_KEY1});
      apb(1'b1, HI, {24'h0, wdtr_pkg::UNLOCK_KEY2});
      apb(1'b0, ST, 32'h0);
      chk(rd, stw(0, 0, 0, 1, 0), "unlocked flag");
      apb(1'b1, LO, 32'h0000_0077);
      apb(1'b0, ST, 32'h0);
      chk(rd, stw(0, 0, 0, 0, 0), "relocked");
      refresh;
      chkcount(rel);
      for (int i = 0; i < 6; i++) begin
         v = 16'($random(seed));
         if (i == 0 || v < 16'h0004) v = 16'h0004;
         if (i == 1) v = 16'hFFFF;
         setrel(v);
         refresh;
         chkcount(rel);
      end
      $display("unlock and reload test done");
      setrel(16'h0004);
      rcOscEnable <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         optResetResponse <= c[0];
         stopMode <= c[1];
         refresh;
         waitto(500);
         chk(32'(n >= (rel - 1) * TC && n <= rel * TC + 1), 1, "delay");
         chk(exceptionReq, !c[0], "exception");
         chk(deviceResetReq, c[0] && !c[1], "reset");
         chk(stopRecoveryReq, c[1], "recovery");
         chk(stopCauseSet, c[1], "stop cause");
         waitto(500);
         chk(n, rel * TC, "self reload period");
         eExc += c[0] ? 0 : 2;
         eRst += (c[0] && !c[1]) ? 2 : 0;
         eRec += c[1] ? 2 : 0;
         @(posedge clk);
      end
      rcOscEnable <= 1'b0;
      repeat (2) @(posedge clk);
      chk(excCount, eExc, "exception count");
      chk(rstCount, eRst, "reset count");
      chk(recCount, eRec, "recovery count");
      apb(1'b0, ST, 32'h0);
      chk(rd, stw(1, 1, 1, 0, 1), "status after time-outs");
      apb(1'b1, ST, stw(0, 1, 1, 0, 0));
      apb(1'b0, ST, 32'h0);
      chk(rd, stw(1, 0, 0, 0, 1), "status cleared");
      $display("time-out test done");
      nb = causeCount;
      debugHalt <= 1'b1;
      rcOscEnable <= 1'b1;
      repeat (200) @(posedge clk);
      chk(causeCount, nb, "halted time-out");
      debugHalt <= 1'b0;
      rcOscEnable <= 1'b0;
      $display("debug halt test done");
      rst <= 1'b1;
      optAlwaysOn <= 1'b1;
      optResetResponse <= 1'b0;
      stopMode <= 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rel = int'(wdtr_pkg::COUNT_RST);
      chkcount(rel);
      apb(1'b0, ST, 32'h0);
      chk(rd, stw(1, 0, 0, 0, 0), "always-on enable");
      rcOscEnable <= 1'b1;
      waitto(5000);
      chk(32'(n >= (rel - 1) * TC && n <= rel * TC + 1), 1, "delay");
      chk(exceptionReq, 1, "always-on exception");
      rcOscEnable <= 1'b0;
      $display("always-on test done");
      end_of_test;
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_of_test;
   end
endmodule
